/* verilog/cld_core.v */
`timescale 1ns/1ps
`include "cld_defines.vh"
module cld_core (
  input wire REF_CLK,
  input wire RSTN,
  input wire [15:0] INSTR,
  output wire [20:0] PM_ADDR,
  output wire [7:0] WORKING_REGISTER,
  output wire [4:0] STATUS,
  output wire [3:0] BANK_SELECT_REGISTER,
  output wire [11:0] POINTER_REGISTER0,
  output wire [11:0] POINTER_REGISTER1,
  output wire [11:0] POINTER_REGISTER2,
  output wire [15:0] PRODUCT,
  output wire [20:0] RETURN_STACK_TOP,
  output wire [4:0] STACK_DEPTH,
  input wire INT_EN_WR,
  input wire [1:0] INT_EN_WDATA,
  output wire GLOBAL_INTERRUPT_ENABLE,
  output wire PERIPHERAL_INTERRUPT_ENABLE,
  output wire WATCHDOG_EXPIRED_FLAG,
  output wire SLEEP_ENTERED_FLAG,
  output wire WDT_CLEAR,
  output wire SLEEP_REQ,
  output wire SW_RESET,
  input wire TBL_PTR_WR,
  input wire [21:0] TBL_PTR_WDATA,
  input wire TBL_LAT_WR,
  input wire [7:0] TBL_LAT_WDATA,
  output wire [21:0] TBL_ADDR,
  output wire [7:0] TBL_LATCH,
  output wire TBL_RD_REQ,
  input wire [7:0] TBL_RD_DATA,
  output wire TBL_WR_REQ,
  input wire TBL_WR_LAUNCH,
  input wire TBL_WR_DONE,
  output wire TBL_BUSY,
  input wire [7:0] PORT_B_PINS,
  output wire [7:0] PORT_B_RMW_SOURCE,
  input wire TIMER_ZERO_WR,
  input wire TIMER_ZERO_HAS_DEST,
  input wire TIMER_ZERO_DEST,
  input wire PRESCALER_ON_TIMER_ZERO,
  output wire PRESCALER_CLR
);
  localparam ST_EXEC = 5'b00001;
  localparam ST_FLUSH = 5'b00010;
  localparam ST_WORD2 = 5'b00100;
  localparam ST_TBL = 5'b01000;
  localparam ST_TWAIT = 5'b10000;

  reg [4:0] state;
  reg [20:0] pc;
  reg [7:0] w;
  reg [4:0] status;
  reg [3:0] bank_select_register;
  reg [11:0] fsr0;
  reg [11:0] fsr1;
  reg [11:0] fsr2;
  reg [15:0] prod;
  reg [20:0] return_stack_top;
  reg [4:0] sp;
  reg [7:0] sh_w;
  reg [4:0] sh_st;
  reg [3:0] sh_bsr;
  reg gie;
  reg peie;
  reg to_flag;
  reg pd_flag;
  reg wdt_clr;
  reg slp_req;
  reg sw_rst;
  reg [21:0] tblptr;
  reg [7:0] tablat;
  reg tbl_rd;
  reg tbl_wr;
  reg [1:0] tmode;
  reg [1:0] w2_kind;
  reg [7:0] w2_lo;
  reg w2_fast;
  reg [7:0] pb_s1;
  reg [7:0] pb_s2;
  reg [7:0] pb_s3;
  reg [7:0] pins;
  reg psc_clr;

  wire [3:0] hi = INSTR[15:12];
  wire [3:0] mid = INSTR[11:8];
  wire [7:0] lo8 = INSTR[7:0];
  wire ex = state[0];
  wire [20:0] pc_inc = pc + `CLD_PC_STEP;
  wire sys = ex && hi == `CLD_HI_SYS && mid == `CLD_LIT_SYS;

  wire [20:0] br_tgt = pc_inc + {{12{lo8[7]}}, lo8, 1'b0};
  wire [20:0] rel_tgt = pc_inc + {{9{INSTR[10]}}, INSTR[10:0], 1'b0};
  wire [20:0] abs_tgt = {INSTR[11:0], w2_lo, 1'b0};

  wire cond_flag = (mid[2:1] == 2'h0) ? status[`CLD_Z] :
                   (mid[2:1] == 2'h1) ? status[`CLD_C] :
                   (mid[2:1] == 2'h2) ? status[`CLD_OV] : status[`CLD_N];
  wire cond_true = cond_flag ^ mid[0];

  // shared adder; subtract is literal plus inverted w plus one
  wire is_sub = mid == `CLD_LIT_SUB;
  wire [7:0] opb = is_sub ? ~w : w;
  wire [8:0] sum9 = {1'b0, lo8} + {1'b0, opb} + {8'h00, is_sub};
  wire [4:0] sum5 = {1'b0, lo8[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub};
  wire ovf = (lo8[7] == opb[7]) && (sum9[7] != lo8[7]);

  // decimal adjust on working register
  wire daw_lo = (w[3:0] > `CLD_BCD_MAX) || status[`CLD_DC];
  wire [8:0] daw1 = {1'b0, w} + (daw_lo ? `CLD_DAW_LO : 9'h000);
  wire daw_hi = (daw1[7:4] > `CLD_BCD_MAX) || status[`CLD_C] || daw1[8];
  wire [8:0] daw2 = daw1 + (daw_hi ? `CLD_DAW_HI : 9'h000);

  // stack traffic
  wire is_push = sys && lo8 == `CLD_SYS_PUSH;
  wire is_relative_subroutine_call = ex && hi == `CLD_HI_REL && mid[3];
  wire is_call2 = state[2] && w2_kind == `CLD_W2_CALL;
  wire stk_push = is_push || is_relative_subroutine_call || is_call2;
  wire stk_pop = (sys && (lo8 == `CLD_SYS_POP || lo8[7:1] == `CLD_SYS_INTERRUPT_RETURN_OP ||
                  lo8[7:1] == `CLD_SYS_RETURN)) ||
                 (ex && hi == `CLD_HI_SYS && mid == `CLD_LIT_RET);
  wire do_push = stk_push && sp != `CLD_STK_DEPTH;
  wire do_pop = stk_pop && sp != 5'h00;
  wire [4:0] next_sp = do_push ? sp + 5'h01 : (do_pop ? sp - 5'h01 : sp);
  wire [20:0] stk_rd;

  cld_stack_mem u_stack (
    .clk(REF_CLK),
    .rstn(RSTN),
    .we(do_push),
    .wa(sp),
    .wd(return_stack_top),
    .ra(next_sp - 5'h01),
    .rd(stk_rd)
  );

  // also used by the software reset opcode
  task reset_core;
    begin
      state <= ST_EXEC;
      pc <= `CLD_PC_RST;
      w <= `CLD_W_RST;
      status <= `CLD_ST_RST;
      bank_select_register <= `CLD_BSR_RST;
      fsr0 <= `CLD_FSR_RST;
      fsr1 <= `CLD_FSR_RST;
      fsr2 <= `CLD_FSR_RST;
      prod <= `CLD_PROD_RST;
      return_stack_top <= `CLD_PC_RST;
      sp <= 5'h00;
      sh_w <= `CLD_W_RST;
      sh_st <= `CLD_ST_RST;
      sh_bsr <= `CLD_BSR_RST;
      gie <= `CLD_GIE_RST;
      peie <= `CLD_GIE_RST;
      to_flag <= `CLD_FLAG_RST;
      pd_flag <= `CLD_FLAG_RST;
      wdt_clr <= 1'b0;
      slp_req <= 1'b0;
      sw_rst <= 1'b0;
      tblptr <= `CLD_TP_RST;
      tablat <= 8'h00;
      tbl_rd <= 1'b0;
      tbl_wr <= 1'b0;
      tmode <= 2'h0;
      w2_kind <= 2'h0;
      w2_lo <= 8'h00;
      w2_fast <= 1'b0;
    end
  endtask

  // pins pass three flops, taken once the last two agree
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pb_s1 <= 8'h00;
      pb_s2 <= 8'h00;
      pb_s3 <= 8'h00;
      pins <= 8'h00;
      psc_clr <= 1'b0;
    end else begin
      pb_s1 <= PORT_B_PINS;
      pb_s2 <= pb_s1;
      pb_s3 <= pb_s2;
      pins <= (pb_s2 & ~(pb_s2 ^ pb_s3)) | (pins & (pb_s2 ^ pb_s3));
      psc_clr <= TIMER_ZERO_WR && (!TIMER_ZERO_HAS_DEST || TIMER_ZERO_DEST) &&
                 PRESCALER_ON_TIMER_ZERO;
    end
  end

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      reset_core;
    end else begin
      wdt_clr <= 1'b0;
      slp_req <= 1'b0;
      sw_rst <= 1'b0;
      tbl_rd <= 1'b0;
      tbl_wr <= 1'b0;
      sp <= next_sp;
      // stack top follows every pop and every push made below full depth
      if (do_push) begin
        return_stack_top <= pc_inc;
      end else if (stk_pop) begin
        return_stack_top <= do_pop ? stk_rd : `CLD_PC_RST;
      end
      if (INT_EN_WR) begin
        gie <= INT_EN_WDATA[1];
        peie <= INT_EN_WDATA[0];
      end
      if (TBL_PTR_WR && !state[3]) begin
        tblptr <= TBL_PTR_WDATA;
      end
      if (TBL_LAT_WR && !state[3]) begin
        tablat <= TBL_LAT_WDATA;
      end
      case (state)
        ST_EXEC: begin
          pc <= pc_inc;
          if (hi == `CLD_HI_CTL) begin
            if (!mid[3]) begin
              if (cond_true) begin
                pc <= br_tgt;
                state <= ST_FLUSH;
              end
            end else if (mid[3:1] == `CLD_CTL_CALL) begin
              // call waits for its second word
              w2_kind <= `CLD_W2_CALL;
              w2_lo <= lo8;
              w2_fast <= mid[0];
              state <= ST_WORD2;
            end else if (mid == `CLD_CTL_ABSOLUTE_JUMP) begin
              // jump waits for its second word
              w2_kind <= `CLD_W2_ABSOLUTE_JUMP;
              w2_lo <= lo8;
              state <= ST_WORD2;
            end else if (mid == `CLD_CTL_LOAD_POINTER_LITERAL) begin
              w2_kind <= `CLD_W2_LOAD_POINTER_LITERAL;
              w2_lo <= lo8;
              state <= ST_WORD2;
            end
          end else if (hi == `CLD_HI_REL) begin
            pc <= rel_tgt;
            state <= ST_FLUSH;
          end else if (hi == `CLD_HI_SYS) begin
            case (mid)
              `CLD_LIT_SYS: begin
                if (lo8 == `CLD_SYS_SLEEP) begin
                  to_flag <= 1'b1;
                  pd_flag <= 1'b0;
                  slp_req <= 1'b1;
                end else if (lo8 == `CLD_SYS_WATCHDOG_CLEAR_OP) begin
                  to_flag <= 1'b1;
                  pd_flag <= 1'b1;
                  wdt_clr <= 1'b1;
                end else if (lo8 == `CLD_SYS_DAW) begin
                  w <= daw2[7:0];
                  status[`CLD_C] <= daw2[8] | status[`CLD_C];
                end else if (lo8 == `CLD_SYS_RESET) begin
                  reset_core;
                  sw_rst <= 1'b1;
                end else if (lo8[7:1] == `CLD_SYS_INTERRUPT_RETURN_OP ||
                             lo8[7:1] == `CLD_SYS_RETURN) begin
                  pc <= return_stack_top;
                  state <= ST_FLUSH;
                  if (lo8[7:1] == `CLD_SYS_INTERRUPT_RETURN_OP) begin
                    gie <= 1'b1;
                    peie <= 1'b1;
                  end
                  if (lo8[0]) begin
                    w <= sh_w;
                    status <= sh_st;
                    bank_select_register <= sh_bsr;
                  end
                end else if (lo8[7:3] == `CLD_SYS_TBL) begin
                  if (lo8[1:0] == `CLD_TM_PREINC) begin
                    tblptr <= tblptr + `CLD_TP_STEP;
                  end
                  tmode <= lo8[1:0];
                  tbl_rd <= !lo8[2];
                  tbl_wr <= lo8[2];
                  state <= ST_TBL;
                end
              end
              `CLD_LIT_BANK: begin
                if (lo8[7:4] == 4'h0) begin
                  bank_select_register <= lo8[3:0];
                end
              end
              `CLD_LIT_ADD, `CLD_LIT_SUB: begin
                w <= sum9[7:0];
                status[`CLD_C] <= sum9[8];
                status[`CLD_DC] <= sum5[4];
                status[`CLD_Z] <= sum9[7:0] == 8'h00;
                status[`CLD_OV] <= ovf;
                status[`CLD_N] <= sum9[7];
              end
              `CLD_LIT_AND: begin
                w <= w & lo8;
                status[`CLD_Z] <= (w & lo8) == 8'h00;
                status[`CLD_N] <= w[7] & lo8[7];
              end
              `CLD_LIT_IOR: begin
                w <= w | lo8;
                status[`CLD_Z] <= (w | lo8) == 8'h00;
                status[`CLD_N] <= w[7] | lo8[7];
              end
              `CLD_LIT_XOR: begin
                w <= w ^ lo8;
                status[`CLD_Z] <= (w ^ lo8) == 8'h00;
                status[`CLD_N] <= w[7] ^ lo8[7];
              end
              `CLD_LIT_RET: begin
                w <= lo8;
                pc <= return_stack_top;
                state <= ST_FLUSH;
              end
              `CLD_LIT_MUL: begin
                prod <= {8'h00, w} * {8'h00, lo8};
              end
              `CLD_LIT_MOV: begin
                w <= lo8;
              end
              default: begin
                w <= w;
              end
            endcase
          end
          // other prefixes, including 1111, fall through as no-operation
        end
        ST_FLUSH: begin
          // second cycle discards the fetched word
          state <= ST_EXEC;
        end
        ST_WORD2: begin
          // second word consumed as operand data
          state <= ST_EXEC;
          if (w2_kind == `CLD_W2_LOAD_POINTER_LITERAL) begin
            pc <= pc_inc;
            if (w2_lo[5:4] == 2'h0) begin
              fsr0 <= {w2_lo[3:0], lo8};
            end else if (w2_lo[5:4] == 2'h1) begin
              fsr1 <= {w2_lo[3:0], lo8};
            end else if (w2_lo[5:4] == 2'h2) begin
              fsr2 <= {w2_lo[3:0], lo8};
            end
          end else begin
            pc <= abs_tgt;
            if (w2_kind == `CLD_W2_CALL && w2_fast) begin
              sh_w <= w;
              sh_st <= status;
              sh_bsr <= bank_select_register;
            end
          end
        end
        ST_TBL: begin
          // read data lands in the latch
          if (tbl_rd) begin
            tablat <= TBL_RD_DATA;
          end
          if (tmode == `CLD_TM_POSTINC) begin
            tblptr <= tblptr + `CLD_TP_STEP;
          end else if (tmode == `CLD_TM_POSTDEC) begin
            tblptr <= tblptr - `CLD_TP_STEP;
          end
          // a launched write extends the instruction
          state <= (tbl_wr && TBL_WR_LAUNCH) ? ST_TWAIT : ST_EXEC;
        end
        ST_TWAIT: begin
          if (TBL_WR_DONE) begin
            state <= ST_EXEC;
          end
        end
        default: begin
          state <= ST_EXEC;
        end
      endcase
    end
  end

  assign PM_ADDR = pc;
  assign WORKING_REGISTER = w;
  assign STATUS = status;
  assign BANK_SELECT_REGISTER = bank_select_register;
  assign POINTER_REGISTER0 = fsr0;
  assign POINTER_REGISTER1 = fsr1;
  assign POINTER_REGISTER2 = fsr2;
  assign PRODUCT = prod;
  assign RETURN_STACK_TOP = return_stack_top;
  assign STACK_DEPTH = sp;
  assign GLOBAL_INTERRUPT_ENABLE = gie;
  assign PERIPHERAL_INTERRUPT_ENABLE = peie;
  assign WATCHDOG_EXPIRED_FLAG = to_flag;
  assign SLEEP_ENTERED_FLAG = pd_flag;
  assign WDT_CLEAR = wdt_clr;
  assign SLEEP_REQ = slp_req;
  assign SW_RESET = sw_rst;
  assign TBL_ADDR = tblptr;
  assign TBL_LATCH = tablat;
  assign TBL_RD_REQ = tbl_rd;
  assign TBL_WR_REQ = tbl_wr;
  assign TBL_BUSY = state[4];
  assign PORT_B_RMW_SOURCE = pins;
  assign PRESCALER_CLR = psc_clr;
endmodule

/* verilog/cld_defines.vh */
`ifndef CLD_DEFINES_VH
`define CLD_DEFINES_VH

// widths and reset values
`define CLD_PC_RST 21'h000000
`define CLD_PC_STEP 21'h000002
`define CLD_STK_DEPTH 5'h1f
`define CLD_TP_RST 22'h000000
`define CLD_TP_STEP 22'h000001
`define CLD_W_RST 8'h00
`define CLD_ST_RST 5'h00
`define CLD_BSR_RST 4'h0
`define CLD_FSR_RST 12'h000
`define CLD_PROD_RST 16'h0000
`define CLD_FLAG_RST 1'b1
`define CLD_GIE_RST 1'b0

// status bit positions
`define CLD_C 0
`define CLD_DC 1
`define CLD_Z 2
`define CLD_OV 3
`define CLD_N 4

// top nibble of the word
`define CLD_HI_SYS 4'h0
`define CLD_HI_REL 4'hd
`define CLD_HI_CTL 4'he

// second nibble under the control prefix
`define CLD_CTL_CALL 3'h6
`define CLD_CTL_ABSOLUTE_JUMP 4'hf
`define CLD_CTL_LOAD_POINTER_LITERAL 4'he

// second nibble under the literal prefix
`define CLD_LIT_SYS 4'h0
`define CLD_LIT_BANK 4'h1
`define CLD_LIT_SUB 4'h8
`define CLD_LIT_IOR 4'h9
`define CLD_LIT_XOR 4'ha
`define CLD_LIT_AND 4'hb
`define CLD_LIT_RET 4'hc
`define CLD_LIT_MUL 4'hd
`define CLD_LIT_MOV 4'he
`define CLD_LIT_ADD 4'hf

// low byte of system words
`define CLD_SYS_SLEEP 8'h03
`define CLD_SYS_WATCHDOG_CLEAR_OP 8'h04
`define CLD_SYS_PUSH 8'h05
`define CLD_SYS_POP 8'h06
`define CLD_SYS_DAW 8'h07
`define CLD_SYS_RESET 8'hff
`define CLD_SYS_INTERRUPT_RETURN_OP 7'h08
`define CLD_SYS_RETURN 7'h09
`define CLD_SYS_TBL 5'h01

// table pointer modes
`define CLD_TM_POSTINC 2'h1
`define CLD_TM_POSTDEC 2'h2
`define CLD_TM_PREINC 2'h3

// pending second-word kinds
`define CLD_W2_CALL 2'h1
`define CLD_W2_ABSOLUTE_JUMP 2'h2
`define CLD_W2_LOAD_POINTER_LITERAL 2'h3

// decimal adjust
`define CLD_DAW_LO 9'h006
`define CLD_DAW_HI 9'h060
`define CLD_BCD_MAX 4'h9

`endif

/* verilog/cld_stack_mem.v */
`timescale 1ns/1ps
module cld_stack_mem (
  input wire clk,
  input wire rstn,
  input wire we,
  input wire [4:0] wa,
  input wire [20:0] wd,
  input wire [4:0] ra,
  output wire [20:0] rd
);
  reg [20:0] mem [0:31];
  reg [20:0] rd_q;

  always @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end

  // bypass so a push followed by a pop sees the fresh entry
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= 21'h000000;
    end else if (we && wa == ra) begin
      rd_q <= wd;
    end else begin
      rd_q <= mem[ra];
    end
  end

  assign rd = rd_q;
endmodule

/* tb/cld_core_assertions.sv */
`timescale 1ns/1ps
module cld_assertions (
  input logic REF_CLK,
  input logic RSTN,
  input logic [15:0] INSTR,
  input logic [20:0] PM_ADDR,
  input logic [7:0] WORKING_REGISTER,
  input logic [4:0] STATUS,
  input logic [3:0] BANK_SELECT_REGISTER,
  input logic [15:0] PRODUCT,
  input logic WATCHDOG_EXPIRED_FLAG,
  input logic SLEEP_ENTERED_FLAG,
  input logic WDT_CLEAR,
  input logic TBL_RD_REQ,
  input logic TBL_WR_REQ,
  input logic TBL_BUSY,
  input logic TBL_WR_DONE,
  input logic TIMER_ZERO_WR,
  input logic TIMER_ZERO_HAS_DEST,
  input logic TIMER_ZERO_DEST,
  input logic PRESCALER_ON_TIMER_ZERO,
  input logic PRESCALER_CLR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // table cycles show a word that is not executed
  wire idle = !TBL_RD_REQ && !TBL_WR_REQ && !TBL_BUSY;
  wire [7:0] k = INSTR[7:0];

  mov_lit_a: assert property (
    INSTR[15:8] == 8'h0e && idle ##1 PM_ADDR == $past(PM_ADDR) + 21'h000002
    |-> WORKING_REGISTER == $past(k) && $stable(STATUS)) else $error("move literal wrong");
  mul_lit_a: assert property (
    INSTR[15:8] == 8'h0d && idle ##1 PM_ADDR == $past(PM_ADDR) + 21'h000002
    |-> PRODUCT == $past(WORKING_REGISTER) * $past(k) && $stable(STATUS))
    else $error("multiply literal wrong");
  bank_load_a: assert property (
    INSTR[15:4] == 12'h010 && idle ##1 PM_ADDR == $past(PM_ADDR) + 21'h000002
    |-> BANK_SELECT_REGISTER == $past(INSTR[3:0]) && $stable(STATUS))
    else $error("bank load wrong");
  and_lit_a: assert property (
    INSTR[15:8] == 8'h0b && idle ##1 PM_ADDR == $past(PM_ADDR) + 21'h000002
    |-> WORKING_REGISTER == ($past(WORKING_REGISTER) & $past(k))
    && STATUS[2] == (WORKING_REGISTER == 8'h00) && STATUS[4] == WORKING_REGISTER[7]
    && STATUS[3] == $past(STATUS[3]) && STATUS[1:0] == $past(STATUS[1:0]))
    else $error("and literal wrong");
  add_lit_a: assert property (
    INSTR[15:8] == 8'h0f && idle ##1 PM_ADDR == $past(PM_ADDR) + 21'h000002
    |-> WORKING_REGISTER == 8'($past(WORKING_REGISTER) + $past(k))
    && STATUS[0] == ((9'h000 + $past(WORKING_REGISTER) + $past(k)) > 9'h0ff)
    && STATUS[2] == (WORKING_REGISTER == 8'h00) && STATUS[4] == WORKING_REGISTER[7])
    else $error("add literal wrong");
  wdt_clear_a: assert property (
    INSTR == 16'h0004 && idle ##1 PM_ADDR == $past(PM_ADDR) + 21'h000002
    |-> WATCHDOG_EXPIRED_FLAG && SLEEP_ENTERED_FLAG ##[0:1] WDT_CLEAR)
    else $error("watchdog clear wrong");
  sleep_flag_a: assert property (
    INSTR == 16'h0003 && idle ##1 PM_ADDR == $past(PM_ADDR) + 21'h000002
    |-> !SLEEP_ENTERED_FLAG && WATCHDOG_EXPIRED_FLAG) else $error("standby flags wrong");
  wr_hold_a: assert property (
    TBL_BUSY && !TBL_WR_DONE |=> TBL_BUSY && $stable(PM_ADDR))
    else $error("memory write dropped");
  presc_clr_a: assert property (
    PRESCALER_CLR == $past(TIMER_ZERO_WR && PRESCALER_ON_TIMER_ZERO
    && (!TIMER_ZERO_HAS_DEST || TIMER_ZERO_DEST))) else $error("prescaler clear wrong");
endmodule

bind cld_core cld_assertions u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .INSTR(INSTR), .PM_ADDR(PM_ADDR),
  .WORKING_REGISTER(WORKING_REGISTER), .STATUS(STATUS),
  .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER), .PRODUCT(PRODUCT),
  .WATCHDOG_EXPIRED_FLAG(WATCHDOG_EXPIRED_FLAG), .SLEEP_ENTERED_FLAG(SLEEP_ENTERED_FLAG),
  .WDT_CLEAR(WDT_CLEAR), .TBL_RD_REQ(TBL_RD_REQ), .TBL_WR_REQ(TBL_WR_REQ),
  .TBL_BUSY(TBL_BUSY), .TBL_WR_DONE(TBL_WR_DONE), .TIMER_ZERO_WR(TIMER_ZERO_WR),
  .TIMER_ZERO_HAS_DEST(TIMER_ZERO_HAS_DEST), .TIMER_ZERO_DEST(TIMER_ZERO_DEST),
  .PRESCALER_ON_TIMER_ZERO(PRESCALER_ON_TIMER_ZERO), .PRESCALER_CLR(PRESCALER_CLR)
);

/* tb/cld_pmem.sv */
`timescale 1ns/1ps
module cld_pmem (
  input logic clk,
  input logic clr,
  input logic we,
  input logic [7:0] wa,
  input logic [15:0] wd,
  input logic [20:0] addr,
  output logic [15:0] instr
);
  logic [15:0] mem [0:255];
  always @(posedge clk) begin
    if (clr) begin
      for (int i = 0; i < 256; i++) mem[i] <= 16'h0000;
    end else if (we) begin
      mem[wa] <= wd;
    end
  end
  // combinational fetch; upper address bits alias
  assign instr = mem[addr[8:1]];
endmodule

/* tb/cld_core_tb_top.sv */
`timescale 1ns/1ps
module cld_core_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clr = 1'b0;
  logic we = 1'b0;
  logic [7:0] wa = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic tpw = 1'b0;
  logic [21:0] tpd = 22'h000000;
  logic [7:0] trd = 8'h5a;
  logic launch = 1'b1;
  logic done = 1'b0;
  logic [7:0] pins = 8'h00;
  logic tzw = 1'b0;
  logic hd = 1'b0;
  logic dst = 1'b0;
  logic pon = 1'b0;
  wire [15:0] instr, prod;
  wire [20:0] pa, return_stack_top;
  wire [7:0] w, tlat, rmw;
  wire [4:0] st, dep;
  wire [3:0] bank_select_register;
  wire [11:0] p0, p1, p2;
  wire [21:0] taddr;
  wire gie, peie, wdf, slf, twq, busy, pclr, slq, swr, trq;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  cld_core dut (
    .REF_CLK(clk), .RSTN(rstn), .INSTR(instr), .PM_ADDR(pa), .WORKING_REGISTER(w),
    .STATUS(st), .BANK_SELECT_REGISTER(bank_select_register), .POINTER_REGISTER0(p0), .POINTER_REGISTER1(p1),
    .POINTER_REGISTER2(p2), .PRODUCT(prod), .RETURN_STACK_TOP(return_stack_top), .STACK_DEPTH(dep),
    .INT_EN_WR(1'b0), .INT_EN_WDATA(2'h0), .GLOBAL_INTERRUPT_ENABLE(gie),
    .PERIPHERAL_INTERRUPT_ENABLE(peie), .WATCHDOG_EXPIRED_FLAG(wdf), .SLEEP_ENTERED_FLAG(slf),
    .WDT_CLEAR(), .SLEEP_REQ(slq), .SW_RESET(swr), .TBL_PTR_WR(tpw), .TBL_PTR_WDATA(tpd),
    .TBL_LAT_WR(1'b0), .TBL_LAT_WDATA(8'h00), .TBL_ADDR(taddr), .TBL_LATCH(tlat),
    .TBL_RD_REQ(trq), .TBL_RD_DATA(trd), .TBL_WR_REQ(twq), .TBL_WR_LAUNCH(launch),
    .TBL_WR_DONE(done), .TBL_BUSY(busy), .PORT_B_PINS(pins), .PORT_B_RMW_SOURCE(rmw),
    .TIMER_ZERO_WR(tzw), .TIMER_ZERO_HAS_DEST(hd), .TIMER_ZERO_DEST(dst),
    .PRESCALER_ON_TIMER_ZERO(pon), .PRESCALER_CLR(pclr)
  );
  cld_pmem u_mem (.clk(clk), .clr(clr), .we(we), .wa(wa), .wd(wd), .addr(pa), .instr(instr));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // hold reset while the program is loaded
  task automatic boot();
    @(posedge clk);
    rstn <= 1'b0;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    wa <= a;
    wd <= d;
  endtask
  task automatic go();
    @(posedge clk);
    we <= 1'b0;
    rstn <= 1'b1;
  endtask

  task automatic lit_ops();
    logic [15:0] p [0:9] = '{16'h0e10, 16'h0f15, 16'h0bf0, 16'h0981, 16'h0d02,
      16'h0aa1, 16'h0801, 16'h0105, 16'hee1a, 16'hf0bc};
    boot();
    foreach (p[i]) put(8'(i), p[i]);
    go();
    cyc(2);
    chk(w, 8'h25, "add result");
    chk(st, 5'h00, "add flags");
    cyc(4);
    chk(w, 8'h00, "xor result");
    chk(st, 5'h04, "logic flags");
    chk(prod, 16'h0142, "product");
    cyc(4);
    chk(w, 8'h01, "subtract result");
    chk(st, 5'h03, "subtract flags");
    chk(bank_select_register, 4'h5, "bank value");
    chk(p1, 12'habc, "pointer value");
    chk({p0, p2}, 24'h000000, "other pointers untouched");
    chk(pa, 21'h000014, "fetch after pointer load");
    $display("lit_ops done");
  endtask

  task automatic flow();
    logic [15:0] p [0:13] = '{16'h0a00, 16'he101, 16'he001, 16'h0e55, 16'hef08, 16'hf000,
      16'h0000, 16'h0000, 16'hec0c, 16'hf000, 16'h0004, 16'hffff, 16'h0e77, 16'h0c66};
    boot();
    foreach (p[i]) put(8'(i), p[i]);
    go();
    cyc(2);
    chk(pa, 21'h000004, "untaken branch");
    cyc(2);
    chk(pa, 21'h000008, "taken branch target");
    cyc(7);
    chk(w, 8'h66, "literal return value");
    chk(pa, 21'h000014, "return address");
    cyc(2);
    chk({wdf, slf}, 2'h3, "watchdog flags");
    chk(pa, 21'h000018, "lone second word");
    chk(w, 8'h66, "lone second word effect");
    $display("flow done");
  endtask

  task automatic stack_ops();
    logic [15:0] p [0:6] = '{16'hec04, 16'hf000, 16'h0003, 16'h00ff, 16'h0005, 16'h0006,
      16'h0010};
    boot();
    foreach (p[i]) put(8'(i), p[i]);
    go();
    cyc(2);
    chk(pa, 21'h000008, "call target");
    chk(return_stack_top, 21'h000004, "call return address");
    chk(dep, 5'h01, "depth after call");
    cyc(1);
    chk(return_stack_top, 21'h00000a, "push");
    chk(dep, 5'h02, "depth after push");
    cyc(1);
    chk(return_stack_top, 21'h000004, "pop");
    chk(dep, 5'h01, "depth after pop");
    cyc(2);
    chk(pa, 21'h000004, "interrupt return");
    chk({gie, peie}, 2'h3, "enables set");
    chk(dep, 5'h00, "depth after interrupt return");
    cyc(1);
    chk({wdf, slf}, 2'h2, "standby flags");
    chk(slq, 1'b1, "standby request pulse");
    cyc(1);
    chk(pa, 21'h000000, "software reset");
    chk(gie, 1'b0, "enables cleared");
    chk(swr, 1'b1, "software reset pulse");
    $display("stack_ops done");
  endtask

  task automatic table_ops();
    logic [15:0] p [0:4] = '{16'h0000, 16'h0000, 16'h0009, 16'h000f, 16'h0000};
    int n;
    int rd_seen = 0;
    boot();
    foreach (p[i]) put(8'(i), p[i]);
    go();
    @(posedge clk);
    tpw <= 1'b1;
    tpd <= 22'h000100;
    @(posedge clk);
    tpw <= 1'b0;
    cyc(0);
    for (n = 0; n < 20 && twq !== 1'b1; n++) begin
      rd_seen += (trq === 1'b1);
      cyc(1);
    end
    chk(rd_seen, 1, "read request pulse");
    chk(twq, 1'b1, "write request");
    chk(taddr, 22'h000102, "pointer modes");
    chk(tlat, 8'h5a, "read latch");
    cyc(6);
    chk(busy, 1'b1, "memory write held");
    @(posedge clk);
    done <= 1'b1;
    cyc(0);
    for (n = 0; n < 10 && busy !== 1'b0; n++) cyc(1);
    chk(busy, 1'b0, "memory write ended");
    @(posedge clk);
    done <= 1'b0;
    $display("table_ops done");
  endtask

  // relative call and jump, return, then a table write that launches nothing
  task automatic rel_ops();
    logic [15:0] p [0:3] = '{16'hd802, 16'h000c, 16'h0012, 16'hd7fe};
    boot();
    foreach (p[i]) put(8'(i), p[i]);
    go();
    launch <= 1'b0;
    cyc(2);
    chk(pa, 21'h000006, "relative call target");
    chk(return_stack_top, 21'h000002, "relative call return");
    chk(dep, 5'h01, "relative call depth");
    cyc(2);
    chk(pa, 21'h000004, "backward relative jump");
    cyc(2);
    chk(pa, 21'h000002, "subroutine return");
    chk(dep, 5'h00, "depth after return");
    cyc(2);
    chk(busy, 1'b0, "write without launch");
    chk(pa, 21'h000004, "write takes two cycles");
    $display("rel_ops done");
  endtask

  task automatic pin_timer();
    @(posedge clk);
    pins <= 8'ha5;
    cyc(8);
    chk(rmw, 8'ha5, "pin levels");
    @(posedge clk);
    tzw <= 1'b1;
    hd <= 1'b1;
    dst <= 1'b0;
    pon <= 1'b1;
    @(posedge clk);
    dst <= 1'b1;
    #1;
    chk(pclr, 1'b0, "no clear without dest");
    @(posedge clk);
    tzw <= 1'b0;
    #1;
    chk(pclr, 1'b1, "prescaler clear");
    $display("pin_timer done");
  endtask

  // tests need well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    lit_ops();
    flow();
    stack_ops();
    table_ops();
    rel_ops();
    pin_timer();
    conclude();
  end
endmodule
